// file: verification/chain_port_properties.sv
// Concurrent checks on the chained serial port
`timescale 1ns/10ps
module chain_port_properties (
    // Clock and reset
    input logic sys_clk,
    input logic rst,
    // Pins and mode state
    input logic interface_mode_pin,
    input logic chip_select_n,
    input logic serial_clk_in,
    input logic serial_clk_out,
    input logic serial_clk_oe_n,
    input logic data_out_oe_n,
    input logic handoff_n,
    input logic conversion_ready_sync_in,
    input logic conversion_ready_sync,
    input logic master_mode
);
    logic       ps;
    logic [8:0] falls;
    wire        sck = master_mode ? serial_clk_out : serial_clk_in;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Raw clock falls since the data pin turned on; slave falls reach the core late
    always @(posedge sys_clk) begin
        ps <= sck;
        if (rst || $fell(data_out_oe_n))
            falls <= 9'h000;
        else if (ps && !sck)
            falls <= falls + 9'h001;
    end
    sequence ready_pulse;
        !conversion_ready_sync ##1 conversion_ready_sync;
    endsequence
    AST_STRAP: assert property ($fell(rst) |-> ##[0:1] master_mode == interface_mode_pin)
        else $error("mode does not follow strap");
    AST_CLK_DRIVE: assert property (master_mode && $past(master_mode) |-> !serial_clk_oe_n)
        else $error("serial clock not driven in master mode");
    AST_CLK_RATE: assert property (master_mode && $changed(serial_clk_out) |=>
        $stable(serial_clk_out)[*4] ##1 $changed(serial_clk_out))
        else $error("serial clock half period wrong");
    AST_READY_LOW: assert property (master_mode && $fell(conversion_ready_sync) |=> ready_pulse)
        else $error("ready pulse width wrong");
    AST_READY_PERIOD: assert property (master_mode && $fell(conversion_ready_sync) |->
        ##64 $fell(conversion_ready_sync))
        else $error("ready period wrong");
    AST_START: assert property ($fell(conversion_ready_sync_in) && !chip_select_n &&
        data_out_oe_n && !handoff_n |-> ##[3:6] !data_out_oe_n)
        else $error("frame did not start");
    AST_HIZ_DONE: assert property (handoff_n |-> data_out_oe_n)
        else $error("data pin driven after hand-off");
    AST_DONE_COUNT: assert property ($rose(handoff_n) |-> falls inside {[143:144]})
        else $error("hand-off before full frame");
    AST_HOLD: assert property (!data_out_oe_n && falls < 9'h08f |-> !handoff_n)
        else $error("hand-off in mid frame");
endmodule
bind chain_serial_port chain_port_properties i_props (.sys_clk(sys_clk), .rst(rst),
    .interface_mode_pin(interface_mode_pin), .chip_select_n(chip_select_n),
    .serial_clk_in(serial_clk_in), .serial_clk_out(serial_clk_out),
    .serial_clk_oe_n(serial_clk_oe_n), .data_out_oe_n(data_out_oe_n), .handoff_n(handoff_n),
    .conversion_ready_sync_in(conversion_ready_sync_in),
    .conversion_ready_sync(conversion_ready_sync), .master_mode(master_mode));

// file: verification/host_model.sv
// Host side of the chain: frame sync, chip select, slave clock, bit capture
`timescale 1ns/10ps
module host_model (
    // Clock
    input  logic         sys_clk,
    // Link
    input  logic         sck,
    input  logic         data_out,
    input  logic         data_out_oe_n,
    output logic         chip_select_n,
    output logic         serial_clk_in,
    output logic         ready_sync_out,
    // Captured frame
    output logic [143:0] bits,
    output logic [8:0]   bit_count
);
    logic ps, hb, ho;
    initial begin
        chip_select_n = 1'b1;
        serial_clk_in = 1'b0;
        ready_sync_out = 1'b1;
        bit_count = 9'h000;
    end
    // A bit stands until the fall, so keep what was seen while high
    always @(posedge sys_clk) begin
        if (sck) begin
            hb <= data_out;
            ho <= data_out_oe_n;
        end
        if (ps && !sck && !ho) begin
            bits <= {bits[142:0], hb};
            bit_count <= bit_count + 9'h001;
        end
        ps <= sck;
    end
    // Conversions run from sys_clk as master clock, source select 0
    // So the serial clock may run only inside the frame, 400 ns a period
    task automatic slave_frame();
        @(posedge sys_clk);
        #1 chip_select_n = 1'b1;
        ready_sync_out = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chip_select_n = 1'b0;
        ready_sync_out = 1'b0;
        bit_count = 9'h000;
        repeat (8) @(posedge sys_clk);
        repeat (144) begin
            #1 serial_clk_in = 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 serial_clk_in = 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
endmodule

// file: verification/tb_chain_serial_port.sv
// Bench for the chained serial port
`timescale 1ns/10ps
module tb_chain_serial_port;
    logic        sys_clk, rst, mode, sample_valid;
    logic [23:0] sample_data;
    int          fail_count, compares;
    wire         cs_n, sclk_in, sclk_out, sclk_oe_n, dout, dout_oe_n, handoff_n;
    wire         crs, host_ready, sample_ready, master_mode;
    wire [143:0] bits;
    wire [8:0]   bit_count;
    wire         ready_in = mode ? crs : host_ready;
    wire         chip_sel = mode ? handoff_n : cs_n;
    // Released data line shows the inverse, so a late capture would show
    wire         dout_line = dout_oe_n ? !dout : dout;
    chain_serial_port i_dut (.sys_clk(sys_clk), .rst(rst), .interface_mode_pin(mode),
        .chip_select_n(chip_sel), .serial_clk_in(sclk_in), .serial_clk_out(sclk_out),
        .serial_clk_oe_n(sclk_oe_n), .data_out(dout), .data_out_oe_n(dout_oe_n),
        .handoff_n(handoff_n), .conversion_ready_sync_in(ready_in),
        .conversion_ready_sync(crs), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .master_mode(master_mode));
    host_model i_host (.sys_clk(sys_clk), .sck(mode ? sclk_out : sclk_in), .data_out(dout_line),
        .data_out_oe_n(dout_oe_n), .chip_select_n(cs_n), .serial_clk_in(sclk_in),
        .ready_sync_out(host_ready), .bits(bits), .bit_count(bit_count));
    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic restart(input logic m);
        @(posedge sys_clk);
        #1 mode = m;
        rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic push(input logic [23:0] w);
        sample_valid = 1'b1;
        sample_data = w;
        for (int i = 0; i < 40 && sample_ready !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        #1;
    endtask
    task automatic slave_case(input logic [23:0] a, b, c, d);
        i_host.slave_frame();
        check(bit_count, 144'h90);
        check(bits, {24'h220000, a, b, c, d, a ^ b ^ c ^ d});
        check(handoff_n, 144'h1);
        check(dout_oe_n, 144'h1);
    endtask
    // Fill until refused while the host stalls, then drain over two frames and send a third from the empty FIFO
    task automatic fill_case();
        for (int i = 0; i < 8; i++)
            push(24'h5a0000 | i[23:0]);
        sample_valid = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check(sample_ready, 144'h0);
        slave_case(24'h5a0000, 24'h5a0001, 24'h5a0002, 24'h5a0003);
        slave_case(24'h5a0004, 24'h5a0005, 24'h5a0006, 24'h5a0007);
        slave_case(24'h000000, 24'h000000, 24'h000000, 24'h000000);
    endtask
    task automatic master_case();
        restart(1'b1);
        check(master_mode, 144'h1);
        check(sclk_oe_n, 144'h0);
        for (int i = 0; i < 200 && dout_oe_n !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        #1 i_host.bit_count = 9'h000;
        for (int i = 0; i < 2000 && handoff_n !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        #1 check(bit_count, 144'h90);
        check(bits, {24'h220000, 120'h0});
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        fail_count++;
        print_verdict();
    end
    initial begin
        fail_count = 0;
        compares = 0;
        rst = 1'b1;
        mode = 1'b0;
        sample_valid = 1'b0;
        sample_data = 24'h000000;
        restart(1'b0);
        fill_case();
        master_case();
        print_verdict();
    end
endmodule

// file: verilog/chain_port_map.vh
// Constants for the chained converter serial port
// Summary of operation
// R1: Interface mode of a device is picked by its mode-select pin level.
// R2: Devices after a master-mode first device must be synchronous slaves.
// R3: Each hand-off output goes to the next device's chip select.
// R4: After shifting out its whole frame, the device deasserts its hand-off output.
// R5: Master chains feed the last hand-off back to the first chip select.
// R6: Once its data is out, the device holds its data output high impedance.
// R7: Host sends commands to a device only while that device is selected.
// R8: First device's data-ready drives every other device's data-ready input.
// R9: In master chains the host uses first data-ready as frame sync.
// R10: In master mode the serial clock runs continuously at internal clock rate.
// R11: All-slave chains clock from external master clock or free serial clock.
// R12: With clock source select 1, master keeps the serial clock running.
// R13: In all-slave chains the bus master synchronizes all conversions.
// R14: In all-slave chains host frame sync drives every data-ready input.
// R15: In all-slave chains master keeps synchronous clock with exact timing.
// R16: Each device sends its own status and integrity words in the frame.
// R17: Host lengthens its frame to cover all chained devices.
// R18: Hand-off stays asserted while shifting; changes only after the final bit.
`ifndef CHAIN_PORT_MAP_VH
`define CHAIN_PORT_MAP_VH
`define WORD_BITS        24
`define FRAME_WORDS      6
`define STATUS_WORD      24'h220000
`define FIFO_DEPTH       8
`define CORE_DIV         5
`define CONV_PERIOD      64
`endif

// file: verilog/chain_serial_port.v
// Daisy-chain serial output port of one converter
`timescale 1ns/10ps
`include "chain_port_map.vh"
module chain_serial_port #(
    parameter WORD_BITS   = `WORD_BITS,
    parameter FRAME_WORDS = `FRAME_WORDS,
    parameter FIFO_DEPTH  = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire                 sys_clk,
    input  wire                 rst,
    // Mode strap
    input  wire                 interface_mode_pin,
    // Serial link pins
    input  wire                 chip_select_n,
    input  wire                 serial_clk_in,
    output reg                  serial_clk_out,
    output reg                  serial_clk_oe_n,
    output reg                  data_out,
    output reg                  data_out_oe_n,
    output reg                  handoff_n,
    // Conversion sync
    input  wire                 conversion_ready_sync_in,
    output reg                  conversion_ready_sync,
    // Converted samples from the core
    input  wire                 sample_valid,
    output reg                  sample_ready,
    input  wire [WORD_BITS-1:0] sample_data,
    // State
    output reg                  master_mode
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_DONE  = 2'd2;
    localparam CW = 5;

    reg [1:0]           state;
    reg [2:0]           cs_sync, sck_sync, rdy_sync;
    reg [2:0]           div_cnt;
    reg [6:0]           conv_cnt;
    reg                 mode_taken;
    reg [1:0]           mode_sync;
    reg [WORD_BITS-1:0] shreg;
    reg [CW-1:0]        bit_cnt;
    reg [3:0]           word_cnt;
    reg [WORD_BITS-1:0] crc_acc;
    wire                cs_act   = !cs_sync[2];
    wire                cs_fall  = cs_sync[2] && !cs_sync[1];
    wire                cs_rise  = !cs_sync[2] && cs_sync[1];
    wire                sck_fall = master_mode ? (div_cnt == 3'd0 && !serial_clk_out)
                                               : (sck_sync[2] && !sck_sync[1]);
    wire                rdy_fall = master_mode ? (conv_cnt == 7'd0)
                                               : (rdy_sync[2] && !rdy_sync[1]);
    wire                fifo_valid;
    wire                fifo_in_ready;
    wire [WORD_BITS-1:0] fifo_data;
    wire                last_word = (word_cnt == FRAME_WORDS[3:0] - 4'd1);
    // A slave shifts only while selected, so later chain members keep their words
    wire                shift_en  = sck_fall && (master_mode || (cs_act && !cs_rise));
    // Pop as the next data word is loaded, so each sample goes out once
    wire                data_word = (word_cnt < FRAME_WORDS[3:0] - 4'd2);
    wire                pop = (state == ST_SHIFT) && shift_en
                              && bit_cnt == WORD_BITS[CW-1:0] - 1'b1 && data_word;

    word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (sample_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data),
        .flush     (1'b0)
    );

    // Three-stage sync; only stages two and three feed logic
    always @(posedge sys_clk) begin
        if (rst) begin
            cs_sync  <= 3'b111;
            sck_sync <= 3'b000;
            rdy_sync <= 3'b111;
        end else begin
            cs_sync  <= {cs_sync[1], cs_sync[0], chip_select_n};
            sck_sync <= {sck_sync[1], sck_sync[0], serial_clk_in};
            rdy_sync <= {rdy_sync[1], rdy_sync[0], conversion_ready_sync_in};
        end
    end

    // Strap flops run through reset, so the level is settled at release
    always @(posedge sys_clk) begin
        mode_sync <= {mode_sync[0], interface_mode_pin};
    end

    // Strap caught once after reset release
    always @(posedge sys_clk) begin
        if (rst) begin
            mode_taken  <= 1'b0;
            master_mode <= 1'b0;
        end else if (!mode_taken) begin
            mode_taken  <= 1'b1;
            master_mode <= mode_sync[1];                           // [R1]
        end
    end

    // Master clock runs free at the internal core clock rate
    always @(posedge sys_clk) begin
        if (rst) begin
            div_cnt         <= 3'd0;
            serial_clk_out  <= 1'b0;
            serial_clk_oe_n <= 1'b1;
            conv_cnt        <= 7'd0;
            conversion_ready_sync <= 1'b1;
        end else begin
            serial_clk_oe_n <= !master_mode;
            if (div_cnt == `CORE_DIV - 1) begin
                div_cnt        <= 3'd0;
                serial_clk_out <= !serial_clk_out;                 // [R10]
            end else begin
                div_cnt <= div_cnt + 3'd1;
            end
            // Held until master mode is known, so the first pulse is full width
            if (!master_mode || conv_cnt == `CONV_PERIOD - 1) begin
                conv_cnt <= 7'd0;
            end else begin
                conv_cnt <= conv_cnt + 7'd1;
            end
            // Frame sync low for two sys_clk cycles, drives the chain's ready inputs
            conversion_ready_sync <= !(master_mode && (conv_cnt < 7'd2)); // [R8]
        end
    end

    // Frame shifter
    always @(posedge sys_clk) begin
        if (rst) begin
            state         <= ST_IDLE;
            shreg         <= {WORD_BITS{1'b0}};
            bit_cnt       <= {CW{1'b0}};
            word_cnt      <= 4'd0;
            crc_acc       <= {WORD_BITS{1'b0}};
            data_out      <= 1'b0;
            data_out_oe_n <= 1'b1;
            handoff_n     <= 1'b0;
            sample_ready  <= 1'b0;
        end else begin
            sample_ready <= fifo_in_ready;
            case (state)
                ST_IDLE: begin
                    data_out_oe_n <= 1'b1;
                    handoff_n     <= 1'b0;
                    if (rdy_fall || (cs_fall && !master_mode)) begin
                        state    <= ST_SHIFT;
                        shreg    <= `STATUS_WORD;                  // [R16]
                        crc_acc  <= {WORD_BITS{1'b0}};
                        bit_cnt  <= {CW{1'b0}};
                        word_cnt <= 4'd0;
                    end
                end
                ST_SHIFT: begin
                    // Held asserted until the last bit is out
                    handoff_n     <= 1'b0;                         // [R18]
                    data_out_oe_n <= !(cs_act || master_mode);
                    data_out      <= shreg[WORD_BITS-1];
                    if (cs_rise && !master_mode) begin
                        // Cut frame: drop the rest rather than resume out of step
                        state <= ST_IDLE;
                    end else if (shift_en) begin
                        shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                        if (bit_cnt == WORD_BITS[CW-1:0] - 1'b1) begin
                            bit_cnt  <= {CW{1'b0}};
                            word_cnt <= word_cnt + 4'd1;
                            if (last_word) begin
                                state <= ST_DONE;
                            end else if (word_cnt == FRAME_WORDS[3:0] - 4'd2) begin
                                shreg <= crc_acc;                  // [R16]
                            end else begin
                                // Empty FIFO sends zeros rather than stalling the frame
                                shreg   <= fifo_valid ? fifo_data : {WORD_BITS{1'b0}};
                                crc_acc <= crc_acc ^ (fifo_valid ? fifo_data
                                                                 : {WORD_BITS{1'b0}});
                            end
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    data_out_oe_n <= 1'b1;                         // [R6]
                    handoff_n     <= 1'b1;                         // [R4]
                    if (!cs_act && !master_mode) begin
                        state <= ST_IDLE;
                    end else if (master_mode && rdy_fall) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: verilog/word_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Flush
    input  wire             flush
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr = in_valid && in_ready;
    wire            do_rd = out_valid && out_ready;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (rst || flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
